// file: logic/ddr2_cmd_ctrl.sv
// Command issuer for a DDR2 SDRAM: tracks every bank and the device-wide state,
// and puts a request on the pins only when it is legal.
// Assumes requests are synchronous to sys_clk and held until acknowledged.
`timescale 1ns/1ns
`default_nettype none
module ddr2_cmd_ctrl (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  // Request port
  input  wire logic                          req_valid,
  input  wire logic [2:0]                    req_cmd,
  input  wire logic [ddr2_pkg::BA_W-1:0]     req_bank,
  input  wire logic [ddr2_pkg::ADDR_W-1:0]   req_addr,
  output logic                               req_ack,
  // Status
  output logic                               all_idle,
  output logic                               dev_busy,
  // Memory command pins
  output logic                               ddr_cke,
  output logic                               ddr_cs_b,
  output logic                               ddr_ras_b,
  output logic                               ddr_cas_b,
  output logic                               ddr_we_b,
  output logic [ddr2_pkg::BA_W-1:0]          ddr_ba,
  output logic [ddr2_pkg::ADDR_W-1:0]        ddr_addr
);
  localparam int NB = ddr2_pkg::NUM_BANKS;
  localparam int CW = ddr2_pkg::CNT_W;

  ddr2_pkg::bank_state_e       bank_st_r [NB];
  ddr2_pkg::bank_state_e       bank_st_nxt [NB];
  logic [CW-1:0]               bank_cnt_r [NB];
  logic [CW-1:0]               bank_cnt_nxt [NB];
  ddr2_pkg::dev_state_e        dev_st_r, dev_st_nxt;
  logic [CW-1:0]               dev_cnt_r, dev_cnt_nxt;
  logic [CW-1:0]               bus_cnt_r, bus_cnt_nxt;
  logic [CW-1:0]               rd_blk_r, rd_blk_nxt;
  logic [CW-1:0]               wr_blk_r, wr_blk_nxt;
  logic [3:0]                  pin_r, pin_nxt;
  logic [ddr2_pkg::BA_W-1:0]   ba_r, ba_nxt;
  logic [ddr2_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic                        ack_r, ack_nxt;
  logic                        cke_r, cke_prev_r;
  logic                        idle_r, idle_nxt;
  logic                        busy_r, busy_nxt;
  logic                        all_idle_c, any_busy_c, legal, take;
  ddr2_pkg::req_cmd_e          cmd;
  ddr2_pkg::bank_state_e       tgt_st;

  assign cmd    = ddr2_pkg::req_cmd_e'(req_cmd);
  assign tgt_st = bank_st_r[req_bank];

  always_comb begin
    all_idle_c = 1'b1;
    any_busy_c = 1'b0;
    for (int b = 0; b < NB; b++) begin
      if (bank_st_r[b] != ddr2_pkg::ST_IDLE) begin
        all_idle_c = 1'b0;
      end
      if (bank_st_r[b] == ddr2_pkg::ST_ACTIVATING || bank_st_r[b] == ddr2_pkg::ST_AUTO_PRE ||
          bank_st_r[b] == ddr2_pkg::ST_PRECHARGING) begin
        any_busy_c = 1'b1;
      end
    end
  end

  // Legality: target bank's state plus shared bus and turnaround counters; precharge-all, refresh and mode load judged on all banks
  always_comb begin
    unique case (cmd)
      ddr2_pkg::CMD_NOP:     legal = 1'b1;
      ddr2_pkg::CMD_ACT:     legal = (tgt_st == ddr2_pkg::ST_IDLE);
      ddr2_pkg::CMD_RD:      legal = (tgt_st == ddr2_pkg::ST_ACTIVE || tgt_st == ddr2_pkg::ST_READ ||
                                      tgt_st == ddr2_pkg::ST_WRITE) && bus_cnt_r == '0 && rd_blk_r == '0;
      ddr2_pkg::CMD_WR:      legal = (tgt_st == ddr2_pkg::ST_ACTIVE || tgt_st == ddr2_pkg::ST_READ ||
                                      tgt_st == ddr2_pkg::ST_WRITE) && bus_cnt_r == '0 && wr_blk_r == '0;
      ddr2_pkg::CMD_PRE:     legal = (tgt_st == ddr2_pkg::ST_ACTIVE || tgt_st == ddr2_pkg::ST_READ ||
                                      tgt_st == ddr2_pkg::ST_WRITE || tgt_st == ddr2_pkg::ST_IDLE) && bus_cnt_r == '0;
      ddr2_pkg::CMD_PRE_ALL: legal = !any_busy_c && bus_cnt_r == '0;
      ddr2_pkg::CMD_REF:     legal = all_idle_c && bus_cnt_r == '0;
      ddr2_pkg::CMD_LM:      legal = all_idle_c && bus_cnt_r == '0;
    endcase
  end

  // CKE held high out of reset, never power-down, so refresh timing stays with the user
  assign take = req_valid && legal && !ack_r && dev_st_r == ddr2_pkg::DEV_NORMAL &&
                cke_r && cke_prev_r;

  always_comb begin
    dev_st_nxt  = dev_st_r;
    dev_cnt_nxt = (dev_cnt_r != '0) ? dev_cnt_r - 1'b1 : dev_cnt_r;
    bus_cnt_nxt = (bus_cnt_r != '0) ? bus_cnt_r - 1'b1 : bus_cnt_r;
    rd_blk_nxt  = (rd_blk_r != '0) ? rd_blk_r - 1'b1 : rd_blk_r;
    wr_blk_nxt  = (wr_blk_r != '0) ? wr_blk_r - 1'b1 : wr_blk_r;
    if (dev_st_r != ddr2_pkg::DEV_NORMAL && dev_cnt_r == '0) begin
      dev_st_nxt = ddr2_pkg::DEV_NORMAL;
    end
    for (int b = 0; b < NB; b++) begin
      bank_st_nxt[b]  = bank_st_r[b];
      bank_cnt_nxt[b] = (bank_cnt_r[b] != '0) ? bank_cnt_r[b] - 1'b1 : bank_cnt_r[b];
      if (bank_cnt_r[b] == '0) begin
        unique case (bank_st_r[b])
          ddr2_pkg::ST_ACTIVATING:  bank_st_nxt[b] = ddr2_pkg::ST_ACTIVE;
          ddr2_pkg::ST_READ:        bank_st_nxt[b] = ddr2_pkg::ST_ACTIVE;
          ddr2_pkg::ST_WRITE:       bank_st_nxt[b] = ddr2_pkg::ST_ACTIVE;
          ddr2_pkg::ST_AUTO_PRE:    bank_st_nxt[b] = ddr2_pkg::ST_IDLE;
          ddr2_pkg::ST_PRECHARGING: bank_st_nxt[b] = ddr2_pkg::ST_IDLE;
          ddr2_pkg::ST_IDLE:        bank_st_nxt[b] = ddr2_pkg::ST_IDLE;
          ddr2_pkg::ST_ACTIVE:      bank_st_nxt[b] = ddr2_pkg::ST_ACTIVE;
          default:                  bank_st_nxt[b] = ddr2_pkg::ST_IDLE;
        endcase
      end
    end
    pin_nxt  = ddr2_pkg::PIN_NOP;
    ba_nxt   = '0;
    addr_nxt = '0;
    ack_nxt  = take;
    if (take) begin
      ba_nxt   = req_bank;
      addr_nxt = req_addr;
      unique case (cmd)
        ddr2_pkg::CMD_NOP: pin_nxt = ddr2_pkg::PIN_NOP;
        ddr2_pkg::CMD_ACT: begin
          pin_nxt                = ddr2_pkg::PIN_ACT;
          bank_st_nxt[req_bank]  = ddr2_pkg::ST_ACTIVATING;
          bank_cnt_nxt[req_bank] = ddr2_pkg::RCD_CYC - 1'b1;
        end
        ddr2_pkg::CMD_RD, ddr2_pkg::CMD_WR: begin
          pin_nxt     = (cmd == ddr2_pkg::CMD_RD) ? ddr2_pkg::PIN_RD : ddr2_pkg::PIN_WR;
          bus_cnt_nxt = ddr2_pkg::BURST_CYC - 1'b1;
          if (cmd == ddr2_pkg::CMD_RD) begin
            wr_blk_nxt = ddr2_pkg::RD2WR_CYC - 1'b1;
          end else begin
            rd_blk_nxt = ddr2_pkg::WR2RD_CYC - 1'b1;
          end
          if (req_addr[ddr2_pkg::AP_BIT]) begin
            bank_st_nxt[req_bank]  = ddr2_pkg::ST_AUTO_PRE;
            bank_cnt_nxt[req_bank] = ((cmd == ddr2_pkg::CMD_RD) ? ddr2_pkg::AP_RD_CYC : ddr2_pkg::AP_WR_CYC) - 1'b1;
          end else begin
            bank_st_nxt[req_bank]  = (cmd == ddr2_pkg::CMD_RD) ? ddr2_pkg::ST_READ : ddr2_pkg::ST_WRITE;
            bank_cnt_nxt[req_bank] = ddr2_pkg::BURST_CYC - 1'b1;
          end
        end
        ddr2_pkg::CMD_PRE: begin
          pin_nxt                        = ddr2_pkg::PIN_PRE;
          addr_nxt[ddr2_pkg::AP_BIT]     = 1'b0;
          bank_st_nxt[req_bank]          = ddr2_pkg::ST_PRECHARGING;
          bank_cnt_nxt[req_bank]         = ddr2_pkg::RP_CYC - 1'b1;
        end
        ddr2_pkg::CMD_PRE_ALL: begin
          pin_nxt                    = ddr2_pkg::PIN_PRE;
          addr_nxt[ddr2_pkg::AP_BIT] = 1'b1;
          dev_st_nxt                 = ddr2_pkg::DEV_PRE_ALL;
          dev_cnt_nxt                = ddr2_pkg::RP_CYC - 1'b1;
          for (int b = 0; b < NB; b++) begin
            bank_st_nxt[b]  = ddr2_pkg::ST_PRECHARGING;
            bank_cnt_nxt[b] = ddr2_pkg::RP_CYC - 1'b1;
          end
        end
        ddr2_pkg::CMD_REF: begin
          pin_nxt     = ddr2_pkg::PIN_REF;
          dev_st_nxt  = ddr2_pkg::DEV_REFRESH;
          dev_cnt_nxt = ddr2_pkg::RFC_CYC - 1'b1;
        end
        ddr2_pkg::CMD_LM: begin
          pin_nxt     = ddr2_pkg::PIN_LM;
          dev_st_nxt  = ddr2_pkg::DEV_MODE_REG;
          dev_cnt_nxt = ddr2_pkg::MRD_CYC - 1'b1;
        end
      endcase
    end
    idle_nxt = 1'b1;
    for (int b = 0; b < NB; b++) begin
      if (bank_st_nxt[b] != ddr2_pkg::ST_IDLE) begin
        idle_nxt = 1'b0;
      end
    end
    busy_nxt = (dev_st_nxt != ddr2_pkg::DEV_NORMAL);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int b = 0; b < NB; b++) begin
        bank_st_r[b]  <= ddr2_pkg::ST_IDLE;
        bank_cnt_r[b] <= '0;
      end
      dev_st_r   <= ddr2_pkg::DEV_NORMAL;
      dev_cnt_r  <= '0;
      bus_cnt_r  <= '0;
      rd_blk_r   <= '0;
      wr_blk_r   <= '0;
      pin_r      <= ddr2_pkg::PIN_DESEL;
      ba_r       <= '0;
      addr_r     <= '0;
      ack_r      <= 1'b0;
      cke_r      <= 1'b0;
      cke_prev_r <= 1'b0;
      idle_r     <= 1'b1;
      busy_r     <= 1'b0;
    end else begin
      bank_st_r  <= bank_st_nxt;
      bank_cnt_r <= bank_cnt_nxt;
      dev_st_r   <= dev_st_nxt;
      dev_cnt_r  <= dev_cnt_nxt;
      bus_cnt_r  <= bus_cnt_nxt;
      rd_blk_r   <= rd_blk_nxt;
      wr_blk_r   <= wr_blk_nxt;
      pin_r      <= pin_nxt;
      ba_r       <= ba_nxt;
      addr_r     <= addr_nxt;
      ack_r      <= ack_nxt;
      cke_r      <= 1'b1;
      cke_prev_r <= cke_r;
      idle_r     <= idle_nxt;
      busy_r     <= busy_nxt;
    end
  end

  assign req_ack   = ack_r;
  assign all_idle  = idle_r;
  assign dev_busy  = busy_r;
  assign ddr_cke   = cke_r;
  assign ddr_cs_b  = pin_r[3];
  assign ddr_ras_b = pin_r[2];
  assign ddr_cas_b = pin_r[1];
  assign ddr_we_b  = pin_r[0];
  assign ddr_ba    = ba_r;
  assign ddr_addr  = addr_r;

  localparam int RCD_D = int'(ddr2_pkg::RCD_CYC);
  localparam int RP_D  = int'(ddr2_pkg::RP_CYC);
  localparam int RFC_D = int'(ddr2_pkg::RFC_CYC);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_TAKE_DRIVES_PINS: assert property (take |=> req_ack && !ddr_cs_b && ddr_ba == $past(req_bank))
    else $error("Taken request not driven on pins");
  AST_ACT_ONLY_IDLE: assert property (take && cmd == ddr2_pkg::CMD_ACT |-> tgt_st == ddr2_pkg::ST_IDLE)
    else $error("Activate to non-idle bank");
  AST_ACT_TIMING: assert property (take && cmd == ddr2_pkg::CMD_ACT && req_bank == '0 |->
                                   ##RCD_D bank_st_r[0] == ddr2_pkg::ST_ACTIVATING ##1 bank_st_r[0] == ddr2_pkg::ST_ACTIVE)
    else $error("Bank 0 activate timing wrong");
  AST_PRE_TIMING: assert property (take && cmd == ddr2_pkg::CMD_PRE && req_bank == '0 |->
                                   ##RP_D bank_st_r[0] == ddr2_pkg::ST_PRECHARGING ##1 bank_st_r[0] == ddr2_pkg::ST_IDLE)
    else $error("Bank 0 precharge timing wrong");
  AST_REF_TIMING: assert property (take && cmd == ddr2_pkg::CMD_REF |=>
                                   dev_busy ##(RFC_D) !dev_busy && all_idle)
    else $error("Refresh period wrong");
  AST_DEV_BUSY_NOP: assert property (dev_st_r != ddr2_pkg::DEV_NORMAL |=> {ddr_cs_b, ddr_ras_b, ddr_cas_b, ddr_we_b} == ddr2_pkg::PIN_NOP)
    else $error("Command during device-wide operation");
  AST_REF_LM_ALL_IDLE: assert property (!ddr_cs_b && !ddr_ras_b && !ddr_cas_b |->
                                        $past(all_idle) && $past(bus_cnt_r == '0))
    else $error("Refresh or mode load with banks not idle");
  AST_WR_AFTER_READ: assert property (take && cmd == ddr2_pkg::CMD_RD |=> !(take && cmd == ddr2_pkg::CMD_WR)[*3])
    else $error("Write too soon after read");
  AST_BURST_UNBROKEN: assert property (take && (cmd == ddr2_pkg::CMD_RD || cmd == ddr2_pkg::CMD_WR) |=>
                                       !(take && (cmd == ddr2_pkg::CMD_RD || cmd == ddr2_pkg::CMD_WR || cmd == ddr2_pkg::CMD_PRE)))
    else $error("Burst interrupted");
  AST_BUSY_BANK_QUIET: assert property (take && cmd != ddr2_pkg::CMD_NOP && cmd != ddr2_pkg::CMD_PRE_ALL &&
                                        cmd != ddr2_pkg::CMD_REF && cmd != ddr2_pkg::CMD_LM |->
                                        !(tgt_st inside {ddr2_pkg::ST_ACTIVATING, ddr2_pkg::ST_AUTO_PRE, ddr2_pkg::ST_PRECHARGING}))
    else $error("Command to busy bank");
  AST_PRE_ALL_VALID: assert property (take && cmd == ddr2_pkg::CMD_PRE_ALL |-> !any_busy_c ##1 ddr_addr[ddr2_pkg::AP_BIT])
    else $error("Precharge all with bank busy");
  AST_CKE_HIGH: assert property (take |-> $past(ddr_cke) && ddr_cke)
    else $error("Command without CKE high");

  COV_ACT_READ: cover property (take && cmd == ddr2_pkg::CMD_ACT ##[1:20] take && cmd == ddr2_pkg::CMD_RD);
  COV_AUTO_PRE: cover property (take && cmd == ddr2_pkg::CMD_WR && req_addr[ddr2_pkg::AP_BIT]);
  COV_REFRESH:  cover property (take && cmd == ddr2_pkg::CMD_REF);
  COV_PRE_ALL:  cover property (take && cmd == ddr2_pkg::CMD_PRE_ALL);
endmodule
`default_nettype wire

// file: logic/ddr2_pkg.sv
// Constants, codes and timing for the DDR2 command-issuing controller.
// Assumes one 125 MHz clock; timing figures are plain defaults to be tuned per part.
package ddr2_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BA_W      = 3;
  localparam int ADDR_W    = 14;
  localparam int AP_BIT    = 10;
  localparam int CNT_W     = 8;

  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RCD_PS      = 15000;
  localparam int T_RP_PS       = 15000;
  localparam int T_RFC_PS      = 195000;
  localparam int T_WR_PS       = 15000;
  localparam int T_WTR_PS      = 7500;
  localparam int T_MRD_TCK     = 2;
  localparam int CAS_LAT       = 5;
  localparam int BURST_LEN     = 4;

  localparam logic [CNT_W-1:0] RCD_CYC   = CNT_W'((T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] RP_CYC    = CNT_W'((T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] RFC_CYC   = CNT_W'((T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WR_CYC    = CNT_W'((T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WTR_CYC   = CNT_W'((T_WTR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] MRD_CYC   = CNT_W'(T_MRD_TCK);
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN / 2);
  localparam logic [CNT_W-1:0] AP_RD_CYC = CNT_W'(BURST_LEN / 2) + RP_CYC;
  localparam logic [CNT_W-1:0] AP_WR_CYC = CNT_W'(CAS_LAT - 1 + BURST_LEN / 2) + WR_CYC + RP_CYC;
  localparam logic [CNT_W-1:0] RD2WR_CYC = CNT_W'(BURST_LEN / 2 + 2);
  localparam logic [CNT_W-1:0] WR2RD_CYC = CNT_W'(CAS_LAT - 1 + BURST_LEN / 2) + WTR_CYC;

  // Pin pattern {cs_b, ras_b, cas_b, we_b}
  localparam logic [3:0] PIN_DESEL = 4'hf;
  localparam logic [3:0] PIN_NOP   = 4'h7;
  localparam logic [3:0] PIN_ACT   = 4'h3;
  localparam logic [3:0] PIN_RD    = 4'h5;
  localparam logic [3:0] PIN_WR    = 4'h4;
  localparam logic [3:0] PIN_PRE   = 4'h2;
  localparam logic [3:0] PIN_REF   = 4'h1;
  localparam logic [3:0] PIN_LM    = 4'h0;

  typedef enum logic [2:0] {
    CMD_NOP     = 3'h0,
    CMD_ACT     = 3'h1,
    CMD_RD      = 3'h2,
    CMD_WR      = 3'h3,
    CMD_PRE     = 3'h4,
    CMD_PRE_ALL = 3'h5,
    CMD_REF     = 3'h6,
    CMD_LM      = 3'h7
  } req_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE        = 3'h0,
    ST_ACTIVATING  = 3'h1,
    ST_ACTIVE      = 3'h2,
    ST_READ        = 3'h3,
    ST_WRITE       = 3'h4,
    ST_AUTO_PRE    = 3'h5,
    ST_PRECHARGING = 3'h6
  } bank_state_e;

  typedef enum logic [1:0] {
    DEV_NORMAL   = 2'h0,
    DEV_REFRESH  = 2'h1,
    DEV_MODE_REG = 2'h2,
    DEV_PRE_ALL  = 2'h3
  } dev_state_e;
endpackage

// file: testbench/ddr2_dev_model.sv
// Behavioural DDR2 device: follows bank and device state from the command pins.
// Assumes pins are sampled on the rising sys_clk edge; each illegal command adds one to viol.
`timescale 1ns/1ns
`default_nettype none
module ddr2_dev_model (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Command pins
  input  wire logic                        ddr_cke,
  input  wire logic                        ddr_cs_b,
  input  wire logic                        ddr_ras_b,
  input  wire logic                        ddr_cas_b,
  input  wire logic                        ddr_we_b,
  input  wire logic [ddr2_pkg::BA_W-1:0]   ddr_ba,
  input  wire logic [ddr2_pkg::ADDR_W-1:0] ddr_addr,
  // Illegal command count
  output logic [15:0]                      viol
);
  ddr2_pkg::bank_state_e st [ddr2_pkg::NUM_BANKS];
  int                    cnt [ddr2_pkg::NUM_BANKS];
  int                    dev_cnt, burst, rd2wr, wr2rd;
  logic                  cke_q, ok, idle_all, ap;
  logic [3:0]            pin;

  function automatic int dn(input int v);
    return (v > 0) ? v - 1 : 0;
  endfunction

  always @(posedge sys_clk) begin
    pin = {ddr_cs_b, ddr_ras_b, ddr_cas_b, ddr_we_b};
    ap = ddr_addr[ddr2_pkg::AP_BIT];
    if (rst_b !== 1'b1) begin
      viol = 16'h0000;
      {dev_cnt, burst, rd2wr, wr2rd} = '0;
      cke_q = 1'b0;
      foreach (st[b]) begin
        st[b] = ddr2_pkg::ST_IDLE;
        cnt[b] = 0;
      end
    end else begin
      idle_all = (burst == 0);
      foreach (st[b]) begin
        // Timed and burst states run out by themselves
        if (st[b] inside {ddr2_pkg::ST_READ, ddr2_pkg::ST_WRITE}) begin
          if (burst == 0) st[b] = ddr2_pkg::ST_ACTIVE;
        end else if (cnt[b] == 0 && st[b] == ddr2_pkg::ST_ACTIVATING) begin
          st[b] = ddr2_pkg::ST_ACTIVE;
        end else if (cnt[b] == 0 && st[b] != ddr2_pkg::ST_ACTIVE) begin
          st[b] = ddr2_pkg::ST_IDLE;
        end
        idle_all &= (st[b] == ddr2_pkg::ST_IDLE);
      end
      ok = 1'b1;
      // Deselect and NOP leave everything running
      if (!pin[3] && pin != ddr2_pkg::PIN_NOP) begin
        ok = ddr_cke && cke_q && dev_cnt == 0;
        case (pin)
          ddr2_pkg::PIN_ACT: begin
            ok &= st[ddr_ba] == ddr2_pkg::ST_IDLE;
            st[ddr_ba] = ddr2_pkg::ST_ACTIVATING;
            cnt[ddr_ba] = ddr2_pkg::RCD_CYC;
          end
          ddr2_pkg::PIN_RD, ddr2_pkg::PIN_WR: begin
            ok &= st[ddr_ba] inside {ddr2_pkg::ST_ACTIVE, ddr2_pkg::ST_READ, ddr2_pkg::ST_WRITE};
            ok &= burst == 0 && ((pin == ddr2_pkg::PIN_RD) ? wr2rd == 0 : rd2wr == 0);
            burst = ddr2_pkg::BURST_CYC;
            if (pin == ddr2_pkg::PIN_RD) rd2wr = ddr2_pkg::RD2WR_CYC;
            else wr2rd = ddr2_pkg::WR2RD_CYC;
            if (ap) begin
              st[ddr_ba] = ddr2_pkg::ST_AUTO_PRE;
              cnt[ddr_ba] = (pin == ddr2_pkg::PIN_RD) ? ddr2_pkg::AP_RD_CYC : ddr2_pkg::AP_WR_CYC;
            end else if (pin == ddr2_pkg::PIN_RD) st[ddr_ba] = ddr2_pkg::ST_READ;
            else st[ddr_ba] = ddr2_pkg::ST_WRITE;
          end
          ddr2_pkg::PIN_PRE: begin
            foreach (st[b]) begin
              if (ap || b == ddr_ba) begin
                ok &= !(st[b] inside {ddr2_pkg::ST_ACTIVATING, ddr2_pkg::ST_AUTO_PRE}) && burst == 0;
                st[b] = ddr2_pkg::ST_PRECHARGING;
                cnt[b] = ddr2_pkg::RP_CYC;
              end
            end
            if (ap) dev_cnt = ddr2_pkg::RP_CYC;
          end
          default: begin
            ok &= idle_all;
            dev_cnt = (pin == ddr2_pkg::PIN_REF) ? ddr2_pkg::RFC_CYC : ddr2_pkg::MRD_CYC;
          end
        endcase
      end
      if (!ok) viol = viol + 16'h0001;
      foreach (cnt[b]) cnt[b] = dn(cnt[b]);
      dev_cnt = dn(dev_cnt);
      burst = dn(burst);
      rd2wr = dn(rd2wr);
      wr2rd = dn(wr2rd);
      cke_q = ddr_cke;
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_ddr2_cmd_ctrl.sv
// Self-checking bench for the DDR2 command controller, with a device model on its pins.
// Assumes the package, design and device model are compiled first; one 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module test_ddr2_cmd_ctrl;
  logic                        sys_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0;
  logic [2:0]                  req_cmd = 3'h0, b;
  logic [ddr2_pkg::BA_W-1:0]   req_bank = '0;
  logic [ddr2_pkg::ADDR_W-1:0] req_addr = '0, a;
  logic                        req_ack, all_idle, dev_busy, ddr_cke, ddr_cs_b, ddr_ras_b, ddr_cas_b, ddr_we_b, ack_q;
  logic [ddr2_pkg::BA_W-1:0]   ddr_ba;
  logic [ddr2_pkg::ADDR_W-1:0] ddr_addr;
  logic [15:0]                 viol;
  logic [20:0]                 pinsv;
  logic [7:0]                  open_b;
  int                          num_errors = 0, compares = 0, cyc = 0, last_ack = 0, brun = 0, blast = 0, r;
  int                          seed = 32'hf16e;

  assign pinsv = {ddr_cs_b, ddr_ras_b, ddr_cas_b, ddr_we_b, ddr_ba, ddr_addr};
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  ddr2_cmd_ctrl u_ddr2_cmd_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_ack(req_ack), .all_idle(all_idle), .dev_busy(dev_busy),
    .ddr_cke(ddr_cke), .ddr_cs_b(ddr_cs_b), .ddr_ras_b(ddr_ras_b), .ddr_cas_b(ddr_cas_b), .ddr_we_b(ddr_we_b),
    .ddr_ba(ddr_ba), .ddr_addr(ddr_addr));
  ddr2_dev_model u_ddr2_dev_model (.sys_clk(sys_clk), .rst_b(rst_b), .ddr_cke(ddr_cke), .ddr_cs_b(ddr_cs_b),
    .ddr_ras_b(ddr_ras_b), .ddr_cas_b(ddr_cas_b), .ddr_we_b(ddr_we_b), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
    .viol(viol));

  task automatic chk_pins(input logic [20:0] got, input logic [20:0] exp, input logic full);
    logic [20:0] m;
    m = full ? 21'h1fffff : 21'h1e0000;
    compares++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Expected pins, bank and address for a request
  function automatic logic [20:0] exp_pins(input logic [2:0] c, input logic [2:0] bk, input logic [13:0] ad);
    logic [3:0] p;
    case (c)
      3'h1: p = ddr2_pkg::PIN_ACT;
      3'h2: p = ddr2_pkg::PIN_RD;
      3'h3: p = ddr2_pkg::PIN_WR;
      3'h4, 3'h5: p = ddr2_pkg::PIN_PRE;
      3'h6: p = ddr2_pkg::PIN_REF;
      3'h7: p = ddr2_pkg::PIN_LM;
      default: p = ddr2_pkg::PIN_NOP;
    endcase
    if (c == 3'h4) ad[10] = 1'b0;
    if (c == 3'h5) ad[10] = 1'b1;
    return {p, bk, ad};
  endfunction

  // Issue one request, wait for its ack, check pins and spacing from the previous ack
  task automatic req(input logic [2:0] c, input logic [2:0] bk, input logic [13:0] ad, input int lo, input int hi);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = bk;
    req_addr = ad;
    do begin
      @(negedge sys_clk);
      n++;
    end while (req_ack !== 1'b1 && n < 500);
    chk_bit(req_ack, 1'b1);
    chk_pins(pinsv, exp_pins(c, bk, ad), c inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h7});
    chk_num(cyc - last_ack, lo, hi);
    last_ack = cyc;
  endtask
  task automatic refuse(input logic [2:0] c, input logic [2:0] bk);
    int k;
    k = 0;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = bk;
    repeat (30) begin
      @(negedge sys_clk);
      if (req_ack === 1'b1) k++;
    end
    req_valid = 1'b0;
    @(negedge sys_clk);
    chk_num(k, 0, 0);
  endtask
  task automatic endtest(input string name);
    chk_bit(viol == 16'h0000, 1'b1);
    $display("test %s finished, errors %0d", name, num_errors);
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Pins fall back to NOP after each command; measure device-wide busy spans
  always @(negedge sys_clk) begin
    if (ack_q === 1'b1) chk_pins(pinsv, {ddr2_pkg::PIN_NOP, 17'h0}, 1'b1);
    ack_q = req_ack;
    if (dev_busy === 1'b1) brun++;
    else if (brun != 0) begin
      blast = brun;
      brun = 0;
    end
  end

  initial begin
    #320000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (2) @(negedge sys_clk);
    chk_bit(ddr_cke, 1'b0);
    chk_pins(pinsv, {ddr2_pkg::PIN_DESEL, 17'h0}, 1'b1);
    chk_bit(all_idle, 1'b1);
    rst_b = 1'b1;
    last_ack = cyc;
    req(3'h1, 3'h0, 14'h0123, 3, 3);
    chk_bit(ddr_cke, 1'b1);
    chk_bit(all_idle, 1'b0);
    req(3'h2, 3'h0, 14'h0010, ddr2_pkg::RCD_CYC + 1, ddr2_pkg::RCD_CYC + 1);
    req(3'h2, 3'h0, 14'h0014, ddr2_pkg::BURST_CYC, 40);
    req(3'h3, 3'h0, 14'h0018, ddr2_pkg::RD2WR_CYC, 40);
    req(3'h2, 3'h0, 14'h0020, ddr2_pkg::WR2RD_CYC, 40);
    req(3'h4, 3'h0, 14'h0400, 2, 40);
    req(3'h1, 3'h0, 14'h0200, ddr2_pkg::RP_CYC + 1, ddr2_pkg::RP_CYC + 1);
    req(3'h1, 3'h1, 14'h0300, 2, 2);
    req(3'h2, 3'h1, 14'h0404, ddr2_pkg::RCD_CYC + 1, ddr2_pkg::RCD_CYC + 1);
    req(3'h1, 3'h1, 14'h0301, ddr2_pkg::AP_RD_CYC + 1, ddr2_pkg::AP_RD_CYC + 1);
    req(3'h3, 3'h0, 14'h0408, 2, 40);
    req(3'h1, 3'h0, 14'h0202, ddr2_pkg::AP_WR_CYC + 1, ddr2_pkg::AP_WR_CYC + 1);
    req(3'h0, 3'h5, 14'h0000, 2, 2);
    refuse(3'h2, 3'h3);
    refuse(3'h3, 3'h3);
    refuse(3'h6, 3'h0);
    refuse(3'h7, 3'h0);
    req(3'h5, 3'h0, 14'h0000, 2, 1000);
    req(3'h6, 3'h0, 14'h0000, ddr2_pkg::RP_CYC + 1, ddr2_pkg::RP_CYC + 1);
    chk_num(blast, ddr2_pkg::RP_CYC, ddr2_pkg::RP_CYC);
    chk_bit(dev_busy, 1'b1);
    req(3'h7, 3'h2, 14'h0042, ddr2_pkg::RFC_CYC + 1, ddr2_pkg::RFC_CYC + 1);
    chk_num(blast, ddr2_pkg::RFC_CYC, ddr2_pkg::RFC_CYC);
    chk_bit(all_idle, 1'b1);
    req(3'h1, 3'h2, 14'h0001, ddr2_pkg::MRD_CYC + 1, ddr2_pkg::MRD_CYC + 1);
    chk_num(blast, ddr2_pkg::MRD_CYC, ddr2_pkg::MRD_CYC);
    endtest("directed");
    open_b = 8'h04;
    for (int i = 0; i < 150; i++) begin
      b = 3'($random(seed));
      r = $random(seed);
      a = 14'($random(seed));
      if (!open_b[b]) begin
        req(3'h1, b, a, 2, 1000);
        open_b[b] = 1'b1;
      end else if (r[2:0] == 3'h3) begin
        req(r[3] ? 3'h2 : 3'h3, b, a | 14'h0400, 2, 1000);
        open_b[b] = 1'b0;
      end else if (r[2:0] == 3'h4) begin
        req(3'h4, b, a, 2, 1000);
        open_b[b] = 1'b0;
      end else if (r[2:0] == 3'h5) begin
        req(3'h5, b, a, 2, 1000);
        req(3'h6, b, a, ddr2_pkg::RP_CYC + 1, 1000);
        req(3'h7, b, a, ddr2_pkg::RFC_CYC + 1, 1000);
        open_b = 8'h00;
      end else begin
        req(r[0] ? 3'h2 : 3'h3, b, a & 14'h3bff, 2, 1000);
      end
    end
    endtest("random");
    summarize();
  end
endmodule
`default_nettype wire
